// ==== rtl/radio_trim_defines.vh ====
// constants for the radio trim and calibration register bank
`ifndef RADIO_TRIM_DEFINES_VH
`define RADIO_TRIM_DEFINES_VH

// register indices as printed; byte address is four times the index
`define IDX_VCO_CURRENT_CAL 12'h82C
`define IDX_VCO_BAND_CAL 12'h82D
`define IDX_VT_XTAL_LOAD 12'h82E
`define IDX_XTAL_CAP_TRIM 12'h82F
`define IDX_RF_CURRENT_RAMP 12'h830
`define IDX_XTAL_DRIVE 12'h831
`define IDX_BATTERY_DETECT 12'h832
`define IDX_TX_DATA_GAIN 12'h833
`define IDX_ANALOG_PIN_ROUTE 12'h834
// extra control word holding the adc source bit
`define IDX_ADC_SOURCE_CTRL 12'h880

`define ADDR_W 16
`define REG_RESET 8'h00
`define VCO_CURRENT_FIXED 4'h8
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// vco_current_calibration write fields
`define CC_OVERRIDE_BIT 7
`define CC_GAIN_HI 6
`define CC_GAIN_LO 5
`define CC_MANUAL_HI 4
`define CC_MANUAL_LO 1
`define CC_SELECT_BIT 0
// vco_band_calibration write fields
`define BC_BAND433_BIT 4
`define BC_SELECT_BIT 3
`define BC_BANK_HI 2
`define BC_BANK_LO 0
// vt_threshold_and_crystal_load
`define VT_ONCHIP_BIT 6
`define VT_LOW_HI 5
`define VT_LOW_LO 3
`define VT_HIGH_HI 2
`define VT_HIGH_LO 0
// crystal_capacitor_trim
`define TRIM_HI 4
`define TRIM_LO 0
// rf_current_and_ramp_scale
`define RAMP_HI 1
`define RAMP_LO 0
// crystal_drive_settings
`define XT_CHARGE_LIMIT_BIT 7
`define XT_OSC_CURRENT_BIT 2
// battery_detect_control
`define BD_BIAS_HI 7
`define BD_BIAS_LO 6
`define BD_REGV_HI 5
`define BD_REGV_LO 4
`define BD_THR_HI 3
`define BD_THR_LO 1
`define BD_ENABLE_BIT 0
// tx_data_and_gain_trim
`define TX_INVERT_BIT 7
// analog_pin_routing
`define PIN_CFG_HI 6
`define PIN_CFG_LO 4
// adc source control word
`define ADC_SRC_BIT 0

`endif

// ==== rtl/radio_trim_calib_registers.v ====
// radio trim and calibration register bank with an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite register port.
`include "radio_trim_defines.vh"

module radio_trim_calib_registers (
    // clock and reset
    input wire SYS_CLK_I,
    input wire RESET_I,
    // axi4-lite write address
    input wire AWVALID_I,
    output wire AWREADY_O,
    input wire [`ADDR_W-1:0] AWADDR_I,
    input wire [2:0] AWPROT_I,
    // axi4-lite write data
    input wire WVALID_I,
    output wire WREADY_O,
    input wire [31:0] WDATA_I,
    input wire [3:0] WSTRB_I,
    // axi4-lite write response
    output wire BVALID_O,
    input wire BREADY_I,
    output wire [1:0] BRESP_O,
    // axi4-lite read address
    input wire ARVALID_I,
    output wire ARREADY_O,
    input wire [`ADDR_W-1:0] ARADDR_I,
    input wire [2:0] ARPROT_I,
    // axi4-lite read data
    output wire RVALID_O,
    input wire RREADY_I,
    output wire [31:0] RDATA_O,
    output wire [1:0] RRESP_O,
    // calibration results from the analog side
    input wire CUR_CAL_DONE_I,
    input wire [3:0] CUR_CAL_RESULT_I,
    input wire CUR_CAL_FAIL_I,
    input wire BAND_CAL_DONE_I,
    input wire [2:0] BAND_CAL_BANK_I,
    input wire BAND_CAL_FAIL_I,
    input wire [1:0] TUNING_COMPARATOR_I,
    input wire BATTERY_LOW_I,
    input wire BROWNOUT_FLAG_I,
    // transmit data path
    input wire TX_DATA_I,
    output wire TX_DATA_O,
    // vco controls
    output wire [3:0] VCO_CURRENT_CODE_O,
    output wire VCO_CURRENT_MANUAL_O,
    output wire BAND_433_ADJUST_O,
    output wire BAND_CAL_SELECT_O,
    output wire [2:0] MANUAL_BANK_CODE_O,
    output wire [2:0] TUNING_LOW_THRESHOLD_O,
    output wire [2:0] TUNING_HIGH_THRESHOLD_O,
    // crystal and power controls
    output wire ONCHIP_LOAD_SELECT_O,
    output wire [4:0] LOAD_TRIM_CODE_O,
    output wire OSC_CURRENT_SELECT_O,
    output wire [1:0] PA_RAMP_SCALE_O,
    output wire [3:0] PA_RAMP_FACTOR_O,
    output wire [2:0] BATTERY_THRESHOLD_CODE_O,
    output wire BATTERY_DETECT_ENABLE_O,
    output wire [1:0] REGULATOR_VOLTAGE_CODE_O,
    // analog test pin routing
    output wire [3:0] ANALOG_ROUTE_CODE_O,
    output wire ADC_SOURCE_SELECT_O
);

    // stored write halves
    reg [7:0] cur_cal_reg;
    reg [7:0] band_cal_reg;
    reg [7:0] vt_load_reg;
    reg [7:0] cap_trim_reg;
    reg [7:0] rf_ramp_reg;
    reg [7:0] xtal_drive_reg;
    reg [7:0] batt_reg;
    reg [7:0] tx_gain_reg;
    reg [7:0] pin_route_reg;
    reg adc_source_reg;

    // calibration status halves
    reg [3:0] cur_auto_reg;
    reg cur_fail_reg;
    reg [2:0] band_auto_reg;
    reg band_fail_reg;

    // bus state
    reg awready_reg;
    reg wready_reg;
    reg aw_full_reg;
    reg w_full_reg;
    reg [11:0] aw_idx_reg;
    reg [7:0] wbyte_reg;
    reg wlane_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg arready_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;

    // registered field outputs
    reg tx_data_reg;
    reg [3:0] vco_code_reg;
    reg vco_manual_reg;
    reg band433_reg;
    reg band_sel_reg;
    reg [2:0] bank_reg;
    reg [2:0] vt_low_reg;
    reg [2:0] vt_high_reg;
    reg onchip_reg;
    reg [4:0] trim_out_reg;
    reg osc_cur_reg;
    reg [1:0] ramp_reg;
    reg [3:0] ramp_factor_reg;
    reg [2:0] batt_thr_reg;
    reg batt_en_reg;
    reg [1:0] regv_reg;
    reg [3:0] route_reg;
    reg adc_src_out_reg;

    wire aw_hs = AWVALID_I & awready_reg;
    wire w_hs = WVALID_I & wready_reg;
    wire ar_hs = ARVALID_I & arready_reg;
    wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire aw_full_next = (aw_full_reg | aw_hs) & ~do_write;
    wire w_full_next = (w_full_reg | w_hs) & ~do_write;
    wire bvalid_next = do_write | (bvalid_reg & ~BREADY_I);
    wire rvalid_next = ar_hs | (rvalid_reg & ~RREADY_I);
    wire [11:0] ar_idx = ARADDR_I[13:2];
    wire wr_hit = (aw_idx_reg >= `IDX_VCO_CURRENT_CAL && aw_idx_reg <= `IDX_ANALOG_PIN_ROUTE)
                  || aw_idx_reg == `IDX_ADC_SOURCE_CTRL;
    // byte lane 0 carries the eight-bit fields; other lanes are dropped
    wire wr_en = do_write & wlane_reg;

    // write channels; address and data may arrive in either order
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_idx_reg <= 12'h000;
            wbyte_reg <= `REG_RESET;
            wlane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else begin
            awready_reg <= ~aw_full_next;
            wready_reg <= ~w_full_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            if (aw_hs) begin
                aw_idx_reg <= AWADDR_I[13:2];
            end
            if (w_hs) begin
                wbyte_reg <= WDATA_I[7:0];
                wlane_reg <= WSTRB_I[0];
            end
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // write halves; status bit positions have no storage here
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cur_cal_reg <= `REG_RESET;
            band_cal_reg <= `REG_RESET;
            vt_load_reg <= `REG_RESET;
            cap_trim_reg <= `REG_RESET;
            rf_ramp_reg <= `REG_RESET;
            xtal_drive_reg <= `REG_RESET;
            batt_reg <= `REG_RESET;
            tx_gain_reg <= `REG_RESET;
            pin_route_reg <= `REG_RESET;
            adc_source_reg <= 1'b0;
        end else if (wr_en) begin
            // reserved bits zeroed in band, cap trim, drive and tx gain words; adc word keeps bit 0 only; others stored as written
            case (aw_idx_reg)
                `IDX_VCO_CURRENT_CAL: cur_cal_reg <= wbyte_reg;
                `IDX_VCO_BAND_CAL: band_cal_reg <= {3'h0, wbyte_reg[4:0]};
                `IDX_VT_XTAL_LOAD: vt_load_reg <= wbyte_reg;
                `IDX_XTAL_CAP_TRIM: cap_trim_reg <= {1'b0, wbyte_reg[6:0]};
                `IDX_RF_CURRENT_RAMP: rf_ramp_reg <= wbyte_reg;
                `IDX_XTAL_DRIVE: xtal_drive_reg <= {wbyte_reg[7], 1'b0, wbyte_reg[5:0]};
                `IDX_BATTERY_DETECT: batt_reg <= wbyte_reg;
                `IDX_TX_DATA_GAIN: tx_gain_reg <= {wbyte_reg[7], 3'h0, wbyte_reg[3:0]};
                `IDX_ANALOG_PIN_ROUTE: pin_route_reg <= wbyte_reg;
                `IDX_ADC_SOURCE_CTRL: adc_source_reg <= wbyte_reg[`ADC_SRC_BIT];
                default: begin
                end
            endcase
        end
    end

    // calibration results latch only on their done strobes
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cur_auto_reg <= 4'h0;
            cur_fail_reg <= 1'b0;
            band_auto_reg <= 3'h0;
            band_fail_reg <= 1'b0;
        end else begin
            if (CUR_CAL_DONE_I) begin
                cur_auto_reg <= CUR_CAL_RESULT_I;
                cur_fail_reg <= CUR_CAL_FAIL_I;
            end
            if (BAND_CAL_DONE_I) begin
                band_auto_reg <= BAND_CAL_BANK_I;
                band_fail_reg <= BAND_CAL_FAIL_I;
            end
        end
    end

    // read channel; data is sampled at the address handshake
    reg [7:0] rd_byte;
    reg rd_hit;
    always @* begin
        rd_byte = `REG_RESET;
        rd_hit = 1'b1;
        case (ar_idx)
            `IDX_VCO_CURRENT_CAL: begin
                // readback follows the calibration select bit
                rd_byte = {3'h0, cur_fail_reg,
                           cur_cal_reg[`CC_SELECT_BIT] ?
                           cur_cal_reg[`CC_MANUAL_HI:`CC_MANUAL_LO] : cur_auto_reg};
            end
            `IDX_VCO_BAND_CAL: begin
                // comparator code 10 is passed as-is; analog never drives it
                rd_byte = {2'h0, TUNING_COMPARATOR_I, band_fail_reg, band_auto_reg};
            end
            `IDX_BATTERY_DETECT: begin
                rd_byte = {3'h0, BATTERY_LOW_I, 3'h0, BROWNOUT_FLAG_I};
            end
            `IDX_ADC_SOURCE_CTRL: begin
                rd_byte = {7'h00, adc_source_reg};
            end
            `IDX_VT_XTAL_LOAD, `IDX_XTAL_CAP_TRIM, `IDX_RF_CURRENT_RAMP,
            `IDX_XTAL_DRIVE, `IDX_TX_DATA_GAIN, `IDX_ANALOG_PIN_ROUTE: begin
                // write-only registers read as zero
                rd_byte = `REG_RESET;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= {24'h000000, rd_byte};
                rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // field outputs, one cycle after the register changes
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tx_data_reg <= 1'b0;
            vco_code_reg <= 4'h0;
            vco_manual_reg <= 1'b0;
            band433_reg <= 1'b0;
            band_sel_reg <= 1'b0;
            bank_reg <= 3'h0;
            vt_low_reg <= 3'h0;
            vt_high_reg <= 3'h0;
            onchip_reg <= 1'b0;
            trim_out_reg <= 5'h00;
            osc_cur_reg <= 1'b0;
            ramp_reg <= 2'h0;
            ramp_factor_reg <= 4'h0;
            batt_thr_reg <= 3'h0;
            batt_en_reg <= 1'b0;
            regv_reg <= 2'h0;
            route_reg <= 4'h0;
            adc_src_out_reg <= 1'b0;
        end else begin
            tx_data_reg <= TX_DATA_I ^ tx_gain_reg[`TX_INVERT_BIT];
            if (cur_cal_reg[`CC_OVERRIDE_BIT]) begin
                vco_code_reg <= cur_cal_reg[`CC_MANUAL_HI:`CC_MANUAL_LO];
            end else begin
                vco_code_reg <= `VCO_CURRENT_FIXED;
            end
            vco_manual_reg <= cur_cal_reg[`CC_SELECT_BIT];
            band433_reg <= band_cal_reg[`BC_BAND433_BIT];
            band_sel_reg <= band_cal_reg[`BC_SELECT_BIT];
            // lower bank code means higher vco frequency, decoded in analog
            bank_reg <= band_cal_reg[`BC_SELECT_BIT] ?
                        band_cal_reg[`BC_BANK_HI:`BC_BANK_LO] : band_auto_reg;
            vt_low_reg <= vt_load_reg[`VT_LOW_HI:`VT_LOW_LO];
            vt_high_reg <= vt_load_reg[`VT_HIGH_HI:`VT_HIGH_LO];
            onchip_reg <= vt_load_reg[`VT_ONCHIP_BIT];
            // trim held at zero while external caps are in use
            trim_out_reg <= vt_load_reg[`VT_ONCHIP_BIT] ?
                            cap_trim_reg[`TRIM_HI:`TRIM_LO] : 5'h00;
            osc_cur_reg <= xtal_drive_reg[`XT_OSC_CURRENT_BIT];
            ramp_reg <= rf_ramp_reg[`RAMP_HI:`RAMP_LO];
            ramp_factor_reg <= 4'h1 << rf_ramp_reg[`RAMP_HI:`RAMP_LO];
            batt_thr_reg <= batt_reg[`BD_THR_HI:`BD_THR_LO];
            batt_en_reg <= batt_reg[`BD_ENABLE_BIT];
            regv_reg <= batt_reg[`BD_REGV_HI:`BD_REGV_LO];
            route_reg <= {adc_source_reg, pin_route_reg[`PIN_CFG_HI:`PIN_CFG_LO]};
            adc_src_out_reg <= adc_source_reg;
        end
    end

    assign AWREADY_O = awready_reg;
    assign WREADY_O = wready_reg;
    assign BVALID_O = bvalid_reg;
    assign BRESP_O = bresp_reg;
    assign ARREADY_O = arready_reg;
    assign RVALID_O = rvalid_reg;
    assign RDATA_O = rdata_reg;
    assign RRESP_O = rresp_reg;
    assign TX_DATA_O = tx_data_reg;
    assign VCO_CURRENT_CODE_O = vco_code_reg;
    assign VCO_CURRENT_MANUAL_O = vco_manual_reg;
    assign BAND_433_ADJUST_O = band433_reg;
    assign BAND_CAL_SELECT_O = band_sel_reg;
    assign MANUAL_BANK_CODE_O = bank_reg;
    assign TUNING_LOW_THRESHOLD_O = vt_low_reg;
    assign TUNING_HIGH_THRESHOLD_O = vt_high_reg;
    assign ONCHIP_LOAD_SELECT_O = onchip_reg;
    assign LOAD_TRIM_CODE_O = trim_out_reg;
    assign OSC_CURRENT_SELECT_O = osc_cur_reg;
    assign PA_RAMP_SCALE_O = ramp_reg;
    assign PA_RAMP_FACTOR_O = ramp_factor_reg;
    assign BATTERY_THRESHOLD_CODE_O = batt_thr_reg;
    assign BATTERY_DETECT_ENABLE_O = batt_en_reg;
    assign REGULATOR_VOLTAGE_CODE_O = regv_reg;
    assign ANALOG_ROUTE_CODE_O = route_reg;
    assign ADC_SOURCE_SELECT_O = adc_src_out_reg;

endmodule // radio_trim_calib_registers

// ==== dv/radio_trim_calib_registers_assertions.sv ====
// concurrent checks for the radio trim register bank
module radio_trim_checker (
    // clock and reset
    input wire SYS_CLK_I,
    input wire RESET_I,
    // register bus
    input wire AWVALID_I,
    input wire AWREADY_O,
    input wire WVALID_I,
    input wire WREADY_O,
    input wire BVALID_O,
    input wire BREADY_I,
    input wire [1:0] BRESP_O,
    input wire ARVALID_I,
    input wire ARREADY_O,
    input wire RVALID_O,
    input wire RREADY_I,
    input wire [31:0] RDATA_O,
    // calibration and fields
    input wire BAND_CAL_DONE_I,
    input wire [2:0] BAND_CAL_BANK_I,
    input wire BAND_CAL_SELECT_O,
    input wire [2:0] MANUAL_BANK_CODE_O,
    input wire ONCHIP_LOAD_SELECT_O,
    input wire [4:0] LOAD_TRIM_CODE_O,
    input wire [1:0] PA_RAMP_SCALE_O,
    input wire [3:0] PA_RAMP_FACTOR_O,
    input wire [3:0] ANALOG_ROUTE_CODE_O,
    input wire ADC_SOURCE_SELECT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_wr_take;
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    endsequence
    sequence s_wr_answer;
        ##[1:2] BVALID_O;
    endsequence
    a_write_answer: assert property (s_wr_take |-> s_wr_answer)
        else $error("write response late");
    a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
        else $error("read data late");
    a_bresp_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("write response dropped");
    a_rdata_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
        else $error("read data dropped");
    a_rdata_upper: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_bank_latch: assert property (BAND_CAL_DONE_I && !BAND_CAL_SELECT_O
        |-> ##2 MANUAL_BANK_CODE_O == $past(BAND_CAL_BANK_I, 2)) else $error("auto bank lost");
    a_trim_gate: assert property (!ONCHIP_LOAD_SELECT_O |-> LOAD_TRIM_CODE_O == 5'h00)
        else $error("trim active with external load");
    a_ramp_factor: assert property (!$past(RESET_I)
        |-> PA_RAMP_FACTOR_O == (4'h1 << PA_RAMP_SCALE_O)) else $error("ramp factor wrong");
    a_route_top: assert property (ANALOG_ROUTE_CODE_O[3] == ADC_SOURCE_SELECT_O)
        else $error("route top bit wrong");
endmodule // radio_trim_checker

bind radio_trim_calib_registers radio_trim_checker u_chk (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
    .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
    .RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .BAND_CAL_DONE_I(BAND_CAL_DONE_I),
    .BAND_CAL_BANK_I(BAND_CAL_BANK_I), .BAND_CAL_SELECT_O(BAND_CAL_SELECT_O),
    .MANUAL_BANK_CODE_O(MANUAL_BANK_CODE_O), .ONCHIP_LOAD_SELECT_O(ONCHIP_LOAD_SELECT_O),
    .LOAD_TRIM_CODE_O(LOAD_TRIM_CODE_O), .PA_RAMP_SCALE_O(PA_RAMP_SCALE_O),
    .PA_RAMP_FACTOR_O(PA_RAMP_FACTOR_O), .ANALOG_ROUTE_CODE_O(ANALOG_ROUTE_CODE_O),
    .ADC_SOURCE_SELECT_O(ADC_SOURCE_SELECT_O)
);

// ==== dv/tb_radio_trim_calib_registers.sv ====
// self-checking bench for the radio trim register bank
`include "radio_trim_defines.vh"
module tb_radio_trim_calib_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, awv, wv, bready, arv, rready, txd;
    logic cur_done, cur_fail, band_done, band_fail, batt_low, brown;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, seed, rv;
    logic [3:0] wstrb, cur_res, m;
    logic [2:0] band_bank;
    logic [1:0] cmp, resp;
    logic [7:0] d [7];
    wire awready, wready, bvalid, arready, rvalid, txo, vcm, b433, bsel, onc, osc, ben, adcs;
    wire [1:0] bresp, rresp, rscale, regv;
    wire [31:0] rdata;
    wire [3:0] vcc, rfac, route;
    wire [2:0] mbank, tlo, thi, bthr;
    wire [4:0] trim;
    int error_cnt, check_count, i, k;
    // first seven are the field words written and checked together in the field test
    localparam logic [11:0] ALL [10] = '{`IDX_VT_XTAL_LOAD, `IDX_XTAL_CAP_TRIM,
        `IDX_RF_CURRENT_RAMP, `IDX_XTAL_DRIVE, `IDX_BATTERY_DETECT, `IDX_ANALOG_PIN_ROUTE,
        `IDX_ADC_SOURCE_CTRL, `IDX_VCO_CURRENT_CAL, `IDX_VCO_BAND_CAL, `IDX_TX_DATA_GAIN};

    radio_trim_calib_registers dut (
        .SYS_CLK_I(clk), .RESET_I(rst), .AWVALID_I(awv), .AWREADY_O(awready),
        .AWADDR_I(awaddr), .AWPROT_I(3'h0), .WVALID_I(wv), .WREADY_O(wready), .WDATA_I(wdata),
        .WSTRB_I(wstrb), .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
        .ARVALID_I(arv), .ARREADY_O(arready), .ARADDR_I(araddr), .ARPROT_I(3'h0),
        .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
        .CUR_CAL_DONE_I(cur_done), .CUR_CAL_RESULT_I(cur_res), .CUR_CAL_FAIL_I(cur_fail),
        .BAND_CAL_DONE_I(band_done), .BAND_CAL_BANK_I(band_bank), .BAND_CAL_FAIL_I(band_fail),
        .TUNING_COMPARATOR_I(cmp), .BATTERY_LOW_I(batt_low), .BROWNOUT_FLAG_I(brown),
        .TX_DATA_I(txd), .TX_DATA_O(txo), .VCO_CURRENT_CODE_O(vcc),
        .VCO_CURRENT_MANUAL_O(vcm), .BAND_433_ADJUST_O(b433), .BAND_CAL_SELECT_O(bsel),
        .MANUAL_BANK_CODE_O(mbank), .TUNING_LOW_THRESHOLD_O(tlo),
        .TUNING_HIGH_THRESHOLD_O(thi), .ONCHIP_LOAD_SELECT_O(onc), .LOAD_TRIM_CODE_O(trim),
        .OSC_CURRENT_SELECT_O(osc), .PA_RAMP_SCALE_O(rscale), .PA_RAMP_FACTOR_O(rfac),
        .BATTERY_THRESHOLD_CODE_O(bthr), .BATTERY_DETECT_ENABLE_O(ben),
        .REGULATOR_VOLTAGE_CODE_O(regv), .ANALOG_ROUTE_CODE_O(route),
        .ADC_SOURCE_SELECT_O(adcs)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [4:0] exp_trim(input logic [7:0] a, input logic [7:0] b);
        return a[6] ? b[4:0] : 5'h00;
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string msg);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    task automatic tmo();
        error_cnt++;
        $display("CHECK FAILED t=%0t bus wait expired", $time);
        end_sim();
    endtask

    // ready is raised only after valid, so the slave must hold its answer
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
        int n;
        awaddr <= {2'b00, a, 2'b00};
        wdata <= {24'h0, v};
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        if (n == 60) tmo();
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        araddr <= {2'b00, a, 2'b00};
        arv <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (arv && arready) arv <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        if (n == 60) tmo();
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        {awv, wv, bready, arv, rready, txd, cur_done, cur_fail} = '0;
        {band_done, band_fail, batt_low, brown, awaddr, araddr, wdata, wstrb} = '0;
        {cur_res, band_bank, cmp} = '0;
        seed = 32'h1509;
        error_cnt = 0;
        check_count = 0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(vcc, 4'h8, "fixed current code");
        for (k = 0; k < 10; k++) begin
            rd(ALL[k]);
            chk(rv, 32'h0, "reset value");
        end
        $display("test reset done");
        rv = rnd();
        m = rv[3:0];
        wr(`IDX_VCO_CURRENT_CAL, {1'b0, 2'b01, m, 1'b1}, 4'h1);
        repeat (3) @(posedge clk);
        chk(vcc, 4'h8, "override off");
        chk(vcm, 1'b1, "current select");
        wr(`IDX_VCO_CURRENT_CAL, {1'b1, 2'b01, m, 1'b1}, 4'h1);
        repeat (3) @(posedge clk);
        chk(vcc, m, "manual current");
        rd(`IDX_VCO_CURRENT_CAL);
        chk(rv, {28'h0, m}, "manual readback");
        cur_res <= ~m;
        cur_fail <= 1'b1;
        cur_done <= 1'b1;
        @(posedge clk);
        cur_done <= 1'b0;
        cur_res <= m;
        cur_fail <= 1'b0;
        wr(`IDX_VCO_CURRENT_CAL, {1'b1, 2'b01, m, 1'b0}, 4'h1);
        rd(`IDX_VCO_CURRENT_CAL);
        chk(rv, {27'h0, 1'b1, ~m}, "auto readback");
        wr(`IDX_VCO_CURRENT_CAL, 8'hFF, 4'h1);
        rd(`IDX_VCO_CURRENT_CAL);
        chk(rv, 32'h1F, "flag survives write");
        $display("test vco current done");
        band_bank <= 3'h5;
        band_fail <= 1'b1;
        band_done <= 1'b1;
        @(posedge clk);
        band_done <= 1'b0;
        band_bank <= 3'h2;
        for (k = 0; k < 8; k++) begin
            rv = rnd();
            d[0] = (k == 0) ? 8'h1F : rv[7:0];
            // comparator walks 00, 01, 11; the analog side never produces 10
            cmp <= {k[1], k[1] | k[0]};
            wr(`IDX_VCO_BAND_CAL, d[0], 4'h1);
            repeat (3) @(posedge clk);
            chk(b433, d[0][4], "band adjust");
            chk(bsel, d[0][3], "band select");
            chk(mbank, d[0][3] ? d[0][2:0] : 3'h5, "bank code");
            rd(`IDX_VCO_BAND_CAL);
            chk(rv, {26'h0, k[1], k[1] | k[0], 4'hD}, "band status");
        end
        $display("test band done");
        for (i = 0; i < 6; i++) begin
            for (k = 0; k < 7; k++) begin
                rv = rnd();
                d[k] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rv[7:0];
                d[k] = d[k] & ((k == 3) ? 8'h7F : (k == 4) ? 8'h3F : 8'hFF);
                wr(ALL[k], d[k], 4'h1);
            end
            repeat (3) @(posedge clk);
            chk(tlo, d[0][5:3], "low threshold");
            chk(thi, d[0][2:0], "high threshold");
            chk(onc, d[0][6], "load select");
            chk(trim, exp_trim(d[0], d[1]), "load trim");
            chk(rscale, d[2][1:0], "ramp scale");
            chk(rfac, 4'h1 << d[2][1:0], "ramp factor");
            chk(osc, d[3][2], "osc current");
            chk(bthr, d[4][3:1], "battery threshold");
            chk(ben, d[4][0], "battery enable");
            chk(regv, d[4][5:4], "regulator code");
            chk(route, {d[6][0], d[5][6:4]}, "pin route");
            chk(adcs, d[6][0], "adc source");
        end
        batt_low <= 1'b1;
        brown <= 1'b1;
        @(posedge clk);
        rd(`IDX_BATTERY_DETECT);
        chk(rv, 32'h11, "battery status");
        $display("test fields done");
        for (i = 0; i < 2; i++) begin
            wr(`IDX_TX_DATA_GAIN, {i[0], 7'h00}, 4'h1);
            repeat (3) @(posedge clk);
            for (k = 0; k < 8; k++) begin
                rv = rnd();
                txd <= rv[0];
                repeat (2) @(posedge clk);
                chk(txo, rv[0] ^ i[0], "tx data");
            end
        end
        $display("test tx done");
        wr(12'h835, 8'hFF, 4'h1);
        chk(resp, `RESP_SLVERR, "unmapped write");
        rd(12'h835);
        chk(resp, `RESP_SLVERR, "unmapped read");
        chk(rv, 32'h0, "unmapped data");
        wr(`IDX_RF_CURRENT_RAMP, ~d[2], 4'h0);
        chk(resp, `RESP_OKAY, "masked write");
        repeat (3) @(posedge clk);
        chk(rscale, d[2][1:0], "masked write kept");
        $display("test refusals done");
        end_sim();
    end
endmodule // tb_radio_trim_calib_registers
